// ==== ips_cpu_model.sv ====
// cpu side model that takes pending external requests
`timescale 1ns/100ps
`default_nettype none
module ips_cpu_model (
    // clock and control
    input  wire logic       clk_sys,
    input  wire logic       ack_en,
    // request side
    input  wire logic       ext_request_any,
    input  wire logic [7:0] ext_request_vector,
    output logic [5:0]      ext_handled
);
    // one-cycle handling pulse for the winning vector
    always_ff @(posedge clk_sys) begin
        if (ack_en && ext_request_any && ext_handled == 6'h00)
            ext_handled <= 6'h01 << (ext_request_vector - 8'h0C);
        else
            ext_handled <= 6'h00;
    end
endmodule
`default_nettype wire

// ==== ips_pkg.sv ====
// package: constants, types and register map of the interrupt flag block
// How it works
// - priority_select_a bit 2 gives the level of 16-bit timer channel 0
// - priority_select_a bit 1 gives the level of 16-bit timer channel 1
// - priority_select_a bit 0 gives the level of 16-bit timer channel 2
// - priority bit 0 means low level 0, 1 means high level 1
// - priority_select_b bit 7 gives one level for 8-bit timers 0 and 1
// - priority_select_b bit 6 gives one level for 8-bit timers 2 and 3
// - priority_select_b bits 5,4,1,0 store writes but steer nothing
// - priority_select_b bit 3 gives the level of serial channel 0
// - priority_select_b bit 2 gives the level of serial channel 1
// - priority_select_b clears on reset and hardware standby
// - request flag bits 7 and 6 ignore writes and read zero
// - flag sets while pin low (level) or on high-to-low (edge)
// - software clears a flag by writing 0 after reading it as 1
// - level mode flag auto-clears when pin high and handling done
// - edge mode flag auto-clears when its handling is carried out
// - writing 1 to a flag does nothing; 0 only clears
// - flags, enables and sense select clear on reset and standby
// - enable bits 5..0 gate external requests 5..0 one by one
// - enable bits 7 and 6 store writes but gate nothing
// - sense bits 5..0: 0 low-level request, 1 falling-edge request
// - sense bits 7 and 6 store writes but change no detection
// - pins are sensed whatever their input or output direction
// - external requests 0..5 use vector numbers 12..17
package ips_pkg;
    localparam int          ADDR_W        = 3;
    localparam int          NUM_EXT       = 6;
    // register offsets
    localparam logic [2:0]  OFF_SENSE     = 3'h0;
    localparam logic [2:0]  OFF_ENABLE    = 3'h1;
    localparam logic [2:0]  OFF_FLAGS     = 3'h2;
    localparam logic [2:0]  OFF_PRIO_A    = 3'h4;
    localparam logic [2:0]  OFF_PRIO_B    = 3'h5;
    // reset values
    localparam logic [7:0]  RST_PRIO_A    = 8'h00;
    localparam logic [7:0]  RST_PRIO_B    = 8'h00;
    localparam logic [7:0]  RST_FLAGS     = 8'h00;
    localparam logic [7:0]  RST_ENABLE    = 8'h00;
    localparam logic [7:0]  RST_SENSE     = 8'h00;
    localparam logic [5:0]  EXT_MASK      = 6'h3F;
    // field positions
    localparam int          BIT_T16_CH0   = 2;
    localparam int          BIT_T16_CH1   = 1;
    localparam int          BIT_T16_CH2   = 0;
    localparam int          BIT_T8_CH01   = 7;
    localparam int          BIT_T8_CH23   = 6;
    localparam int          BIT_SERIAL0   = 3;
    localparam int          BIT_SERIAL1   = 2;
    localparam int          BIT_EXT01_LO  = 7;
    // vector numbers of external requests
    localparam logic [7:0]  VEC_EXT_BASE  = 8'h0C;
    localparam logic [7:0]  VEC_NONE      = 8'h00;

    // register bus request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ips_bus_t;

    // priority levels of internal sources
    typedef struct packed {
        logic t16_ch0;
        logic t16_ch1;
        logic t16_ch2;
        logic t8_ch01;
        logic t8_ch23;
        logic serial0;
        logic serial1;
    } ips_prio_t;

    // whole block state
    typedef struct packed {
        logic [7:0] priority_select_a;
        logic [7:0] priority_select_b;
        logic [5:0] ext_request_flags;
        logic [7:0] ext_request_enables;
        logic [7:0] ext_sense_select;
        logic [5:0] read_as_one;
        logic [5:0] pin_prev;
        logic [7:0] rdata;
        logic [5:0] req;
        logic       req_any;
        logic       req_level;
        logic [7:0] req_vector;
    } ips_state_t;
endpackage

// ==== ips_properties.sv ====
// port checker of the interrupt flag block
`timescale 1ns/100ps
`default_nettype none
module ips_properties (
    // watched ports
    input wire logic               clk_sys,
    input wire logic               resetn,
    input wire logic               hw_standby,
    input wire ips_pkg::ips_bus_t  bus,
    input wire logic [7:0]         rdata,
    input wire logic [5:0]         ext_request,
    input wire logic               ext_request_any,
    input wire logic               ext_request_level,
    input wire logic [7:0]         ext_request_vector,
    input wire ips_pkg::ips_prio_t prio
);
    import ips_pkg::*;
    // one clock domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_ANY: assert property (
        ext_request_any == (|ext_request)) else $error("summary bit");
    AST_IDLE: assert property (
        !ext_request_any |-> !ext_request_level && ext_request_vector == 8'h00)
        else $error("idle vector");
    AST_VEC: assert property (
        ext_request_any |-> ext_request_vector inside {[8'h0C:8'h11]} &&
        ext_request[3'(ext_request_vector - VEC_EXT_BASE)])
        else $error("vector source");
    AST_PRIO_A: assert property (
        bus.wr && bus.addr == OFF_PRIO_A && !hw_standby |=>
        prio[6:4] == $past(bus.wdata[2:0])) else $error("timer16 level");
    AST_PRIO_B: assert property (
        bus.wr && bus.addr == OFF_PRIO_B && !hw_standby |=>
        prio[3:0] == {$past(bus.wdata[7:6]), $past(bus.wdata[3:2])})
        else $error("timer8 or serial level");
    AST_FLAG_HI: assert property (
        bus.rd && bus.addr == OFF_FLAGS |=> rdata[7:6] == 2'b00)
        else $error("flag top bits");
    AST_STBY: assert property (
        hw_standby |=> ext_request == 6'h00 && rdata == 8'h00 && prio == 7'h00)
        else $error("standby clear");
    AST_GATE: assert property (
        bus.wr && bus.addr == OFF_ENABLE |-> ##2
        (ext_request & ~$past(bus.wdata[5:0], 2)) == 6'h00)
        else $error("disabled request");
endmodule
bind ips_top ips_properties chk_u (.clk_sys(clk_sys), .resetn(resetn),
    .hw_standby(hw_standby), .bus(bus), .rdata(rdata),
    .ext_request(ext_request), .ext_request_any(ext_request_any),
    .ext_request_level(ext_request_level),
    .ext_request_vector(ext_request_vector), .prio(prio));
`default_nettype wire

// ==== ips_top.sv ====
// interrupt priority, external request flag, enable and sense logic
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ips_top (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              hw_standby,
    // register port
    input  wire ips_pkg::ips_bus_t bus,
    output logic [7:0]             rdata,
    // external request pins, active low
    input  wire logic [5:0]        ext_req_n,
    // cpu exception side
    input  wire logic [5:0]        ext_handled,
    output logic [5:0]             ext_request,
    output logic                   ext_request_any,
    output logic                   ext_request_level,
    output logic [7:0]             ext_request_vector,
    output ips_pkg::ips_prio_t     prio
);
    import ips_pkg::*;

    logic       rst_s1;
    logic       rst_s2;
    ips_state_t st;
    ips_state_t next_st;

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // priority level of an external request from priority_select_a
    function automatic logic ext_level(input logic [7:0] pa, input int n);
        logic r;
        r = 1'b0;
        case (n)
            0:       r = pa[BIT_EXT01_LO];
            1:       r = pa[BIT_EXT01_LO - 1];
            2, 3:    r = pa[BIT_EXT01_LO - 2];
            default: r = pa[BIT_EXT01_LO - 3];
        endcase
        return r;
    endfunction

    // next state: register access, flag set and clear, request output
    always_comb begin
        logic [5:0] set_ev;
        logic [5:0] auto_clr;
        logic [5:0] sw_clr;
        logic [5:0] pend;
        set_ev   = '0;
        auto_clr = '0;
        sw_clr   = '0;
        pend     = '0;
        next_st  = st;
        // pins sampled regardless of direction
        next_st.pin_prev = ext_req_n;
        for (int n = 0; n < NUM_EXT; n++) begin
            if (!st.ext_sense_select[n]) begin
                set_ev[n]   = !ext_req_n[n];
                auto_clr[n] = ext_req_n[n] && ext_handled[n];
            end else begin
                set_ev[n]   = st.pin_prev[n] && !ext_req_n[n];
                auto_clr[n] = ext_handled[n];
            end
        end
        // software write
        if (bus.wr) begin
            unique case (bus.addr)
                OFF_PRIO_A: next_st.priority_select_a = bus.wdata;
                OFF_PRIO_B: next_st.priority_select_b = bus.wdata;
                OFF_ENABLE: next_st.ext_request_enables = bus.wdata;
                OFF_SENSE:  next_st.ext_sense_select = bus.wdata;
                OFF_FLAGS:  sw_clr = ~bus.wdata[5:0] & st.read_as_one;
                default:    ;
            endcase
        end
        // flags: set wins over clears; write of 1 ignored
        next_st.ext_request_flags =
            (st.ext_request_flags & ~(sw_clr | auto_clr)) | set_ev;
        // record of a read as 1, dropped once the flag falls
        next_st.read_as_one = st.read_as_one & next_st.ext_request_flags;
        if (bus.rd && bus.addr == OFF_FLAGS) begin
            next_st.read_as_one = st.ext_request_flags
                                  & next_st.ext_request_flags;
        end
        if (bus.wr && bus.addr == OFF_FLAGS) begin
            next_st.read_as_one = '0;
        end
        // read data
        next_st.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                OFF_PRIO_A: next_st.rdata = st.priority_select_a;
                OFF_PRIO_B: next_st.rdata = st.priority_select_b;
                OFF_ENABLE: next_st.rdata = st.ext_request_enables;
                OFF_SENSE:  next_st.rdata = st.ext_sense_select;
                OFF_FLAGS:  next_st.rdata = {2'b00, st.ext_request_flags};
                default:    next_st.rdata = 8'h00;
            endcase
        end
        // request to the cpu: flag and enable
        pend = st.ext_request_flags & st.ext_request_enables[5:0] & EXT_MASK;
        next_st.req        = pend;
        next_st.req_any    = |pend;
        next_st.req_level  = 1'b0;
        next_st.req_vector = VEC_NONE;
        // lowest number wins within the higher level
        for (int n = NUM_EXT - 1; n >= 0; n--) begin
            if (pend[n] && !ext_level(st.priority_select_a, n)
                && !next_st.req_level) begin
                next_st.req_vector = VEC_EXT_BASE + 8'(n);
            end
        end
        for (int n = NUM_EXT - 1; n >= 0; n--) begin
            if (pend[n] && ext_level(st.priority_select_a, n)) begin
                next_st.req_level  = 1'b1;
                next_st.req_vector = VEC_EXT_BASE + 8'(n);
            end
        end
    end

    // state register; reset and hardware standby clear all of it but pin_prev
    always_ff @(posedge clk_sys or negedge rst_s2) begin
        if (!rst_s2) begin
            st <= '0;
            st.priority_select_a <= RST_PRIO_A;
            st.priority_select_b <= RST_PRIO_B;
            st.ext_request_flags <= RST_FLAGS[5:0];
            st.ext_request_enables <= RST_ENABLE;
            st.ext_sense_select <= RST_SENSE;
            st.pin_prev <= 6'h3F;
        end else if (hw_standby) begin
            st <= '0;
            st.pin_prev <= ext_req_n;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign rdata              = st.rdata;
    assign ext_request        = st.req;
    assign ext_request_any    = st.req_any;
    assign ext_request_level  = st.req_level;
    assign ext_request_vector = st.req_vector;
    // internal source levels
    assign prio.t16_ch0 = st.priority_select_a[BIT_T16_CH0];
    assign prio.t16_ch1 = st.priority_select_a[BIT_T16_CH1];
    assign prio.t16_ch2 = st.priority_select_a[BIT_T16_CH2];
    assign prio.t8_ch01 = st.priority_select_b[BIT_T8_CH01];
    assign prio.t8_ch23 = st.priority_select_b[BIT_T8_CH23];
    assign prio.serial0 = st.priority_select_b[BIT_SERIAL0];
    assign prio.serial1 = st.priority_select_b[BIT_SERIAL1];
endmodule
`default_nettype wire

// ==== irq_priority_sense_flags_tb.sv ====
// testbench of the interrupt flag block
`timescale 1ns/100ps
`default_nettype none
module irq_priority_sense_flags_tb;
    import ips_pkg::*;
    logic       clk_sys = 1'b0;
    logic       resetn = 1'b0;
    logic       hw_standby = 1'b0;
    logic       ack_en = 1'b0;
    ips_bus_t   bus = '0;
    logic [5:0] ext_req_n = 6'h3F;
    logic [5:0] ext_request, ext_handled;
    logic [7:0] rdata, ext_request_vector;
    logic       ext_request_any, ext_request_level;
    ips_prio_t  prio;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         cycles = 0;
    ips_top dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .hw_standby(hw_standby), .bus(bus), .rdata(rdata),
        .ext_req_n(ext_req_n), .ext_handled(ext_handled),
        .ext_request(ext_request), .ext_request_any(ext_request_any),
        .ext_request_level(ext_request_level),
        .ext_request_vector(ext_request_vector), .prio(prio));
    ips_cpu_model cpu_u (.clk_sys(clk_sys), .ack_en(ack_en),
        .ext_request_any(ext_request_any),
        .ext_request_vector(ext_request_vector), .ext_handled(ext_handled));
    // clock and hang limit
    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude;
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    // bus cycles, pins and waits
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rc(input string n, input logic [2:0] a, logic [7:0] e);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk(n, rdata, e);
    endtask
    task automatic pin(input logic [5:0] v);
        @(posedge clk_sys);
        ext_req_n <= v;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // scenarios
    task automatic t_regs;
        for (int a = 0; a < 8; a++)
            wr(3'(a), 8'hFF);
        rc("sense", OFF_SENSE, 8'hFF);
        rc("enable", OFF_ENABLE, 8'hFF);
        rc("flags", OFF_FLAGS, 8'h00);
        rc("unmapped", 3'h3, 8'h00);
        rc("prio b", OFF_PRIO_B, 8'hFF);
        wr(OFF_PRIO_A, 8'h05);
        wr(OFF_PRIO_B, 8'h88);
        chk("prio a", prio[6:4], 8'h05);
        chk("prio b", prio[3:0], 8'h0A);
        wr(OFF_PRIO_A, 8'h32);
        wr(OFF_PRIO_B, 8'h77);
        chk("prio a", prio[6:4], 8'h02);
        chk("prio b", prio[3:0], 8'h05);
    endtask
    task automatic t_level;
        wr(OFF_SENSE, 8'h00);
        wr(OFF_ENABLE, 8'hC0);
        pin(6'h3E);
        pin(6'h3F);
        tick(2);
        chk("gated", ext_request, 8'h00);
        wr(OFF_FLAGS, 8'h00);
        rc("unread", OFF_FLAGS, 8'h01);
        wr(OFF_ENABLE, 8'h01);
        tick(2);
        chk("vector", ext_request_vector, 8'h0C);
        wr(OFF_FLAGS, 8'hFE);
        rc("cleared", OFF_FLAGS, 8'h00);
        pin(6'h3E);
        ack_en <= 1'b1;
        tick(6);
        rc("held low", OFF_FLAGS, 8'h01);
        pin(6'h3F);
        tick(6);
        rc("auto", OFF_FLAGS, 8'h00);
        ack_en <= 1'b0;
    endtask
    task automatic t_edge;
        wr(OFF_SENSE, 8'h20);
        wr(OFF_ENABLE, 8'h28);
        wr(OFF_PRIO_A, 8'h10);
        pin(6'h17);
        tick(3);
        chk("winner", ext_request_vector, 8'h11);
        chk("level", ext_request_level, 8'h01);
        rc("edge", OFF_FLAGS, 8'h28);
        wr(OFF_FLAGS, 8'hDF);
        rc("low held", OFF_FLAGS, 8'h08);
        pin(6'h3F);
        pin(6'h17);
        ack_en <= 1'b1;
        tick(8);
        rc("handled", OFF_FLAGS, 8'h08);
        chk("next", ext_request_vector, 8'h0F);
        ack_en <= 1'b0;
        pin(6'h3F);
    endtask
    task automatic t_clear(input string n);
        for (int a = 0; a < 8; a++)
            rc(n, 3'(a), 8'h00);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        tick(3);
        t_clear("reset");
        t_regs();
        t_level();
        t_edge();
        pin(6'h3E);
        hw_standby <= 1'b1;
        pin(6'h3F);
        hw_standby <= 1'b0;
        t_clear("standby");
        conclude();
    end
endmodule
`default_nettype wire
